/* File: pkg/erl_pkg.sv */
// Constants, register map and state types of the event recovery supervisor.
// Assumes one 40 MHz clock and a 32-bit AHB-Lite register port.
package erl_pkg;

    // ------------------------------------------------------------
    // Sizes and clock
    // ------------------------------------------------------------
    localparam int EVENT_COUNT = 8;
    localparam int CLOCK_HZ = 40000000;
    localparam logic [15:0] MAX_RECOV_RESET = 16'h0000;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // Parameter indices of the maximum-recovery settings
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_MAX_LOG_MISSED = 12'h2fc;
    localparam logic [11:0] IDX_MAX_USER_DISABLE = 12'h2fd;
    localparam logic [11:0] IDX_MAX_POS_LIMIT = 12'h2fe;
    localparam logic [11:0] IDX_MAX_NEG_LIMIT = 12'h2ff;
    localparam logic [11:0] IDX_MAX_CURRENT_LIMIT = 12'h300;
    localparam logic [11:0] IDX_MAX_CONT_CURRENT_LIMIT = 12'h301;
    localparam logic [11:0] IDX_MAX_LOOP_SATURATED = 12'h302;
    localparam logic [11:0] IDX_MAX_USER_UNDERVOLT = 12'h303;
    localparam logic [11:0] ADDR_MAX_FIRST = 12'(IDX_MAX_LOG_MISSED * 4);
    localparam logic [11:0] ADDR_MAX_LAST = 12'(IDX_MAX_USER_UNDERVOLT * 4);

    // ------------------------------------------------------------
    // Control, status and interrupt registers (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_ACTION = 12'h004;
    localparam logic [11:0] ADDR_TIMEOUT_WIN = 12'h008;
    localparam logic [11:0] ADDR_RECOV_TIME = 12'h00c;
    localparam logic [11:0] ADDR_EVENT_STATE = 12'h010;
    localparam logic [11:0] ADDR_LATCH_RESET = 12'h014;
    localparam logic [11:0] ADDR_COUNT_CLEAR = 12'h018;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h01c;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h020;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h024;
    localparam logic [11:0] ADDR_COUNT_FIRST = 12'h040;
    localparam logic [11:0] ADDR_COUNT_LAST = 12'h05c;
    localparam logic [15:0] TIMEOUT_WIN_RESET = 16'h0000;
    localparam logic [15:0] RECOV_TIME_RESET = 16'h0000;
    localparam logic [7:0] ACTION_RESET = 8'hff;

    // ------------------------------------------------------------
    // State of one event supervisor
    // ------------------------------------------------------------
    typedef struct packed {
        logic prevLevel;
        logic pending;
        logic latched;
        logic [17:0] clearCnt;
        logic [15:0] recovCount;
        logic occurred;
        logic latchedPulse;
    } sup_state_t;

    // ------------------------------------------------------------
    // State of the top block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic wrPending;
        logic [11:0] wrAddr;
        logic rdLate;
        logic [11:0] rdAddr;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic [7:0][15:0] maxRecov;
        logic bridgeReq;
        logic [7:0] action;
        logic [15:0] timeoutWin;
        logic [15:0] recovTime;
        logic [15:0] irqStatus;
        logic [15:0] irqEnable;
        logic [7:0] latchReset;
        logic [7:0] countClear;
        logic bridgeEnable;
        logic [7:0] eventAction;
        logic [7:0] latchedEvents;
        logic irq;
    } top_state_t;

endpackage : erl_pkg

/* File: pkg/event_sup_if.sv */
// Signals between the top block and one event supervisor.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface event_sup_if;
    logic eventLevel;
    logic [15:0] maxRecov;
    logic [16:0] clearTime;
    logic latchReset;
    logic countClear;
    logic latched;
    logic pending;
    logic [15:0] recovCount;
    logic occurred;
    logic latchedPulse;

    modport sup (
        input eventLevel, maxRecov, clearTime, latchReset, countClear,
        output latched, pending, recovCount, occurred, latchedPulse
    );
    modport ctl (
        output eventLevel, maxRecov, clearTime, latchReset, countClear,
        input latched, pending, recovCount, occurred, latchedPulse
    );
endinterface : event_sup_if

/* File: hw/event_supervisor.sv */
// Recovery counting and latching for one monitored event.
// Assumes a level already synchronised to the clock.
`timescale 1ns/1ps
module event_supervisor
    import erl_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    event_sup_if.sup port
);

    sup_state_t s;
    sup_state_t next_s;
    logic [15:0] bumped;

    // Next state of the supervisor
    always_comb begin
        next_s = s;
        bumped = (s.recovCount == 16'hffff) ? s.recovCount : s.recovCount + 16'h0001;
        next_s.prevLevel = port.eventLevel;
        next_s.occurred = port.eventLevel & ~s.prevLevel;
        next_s.latchedPulse = 1'b0;
        if (port.eventLevel) begin
            next_s.pending = ~s.latched;
            next_s.clearCnt = '0;
        end else if (s.pending) begin
            if (s.clearCnt > {1'b0, port.clearTime}) begin
                next_s.pending = 1'b0;
                next_s.clearCnt = '0;
                next_s.recovCount = bumped;
                if (bumped >= port.maxRecov) begin
                    next_s.latched = 1'b1;
                    next_s.latchedPulse = 1'b1;
                end
            end else begin
                next_s.clearCnt = s.clearCnt + 18'h00001;
            end
        end
        // Explicit reset; a latch set in the same cycle wins
        if (port.latchReset && !next_s.latchedPulse) begin
            next_s.latched = 1'b0;
        end
        // Counter clear only on the tool-gated strobe
        if (port.countClear) begin
            next_s.recovCount = '0;
        end
    end

    // State register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign port.latched = s.latched;
    assign port.pending = s.pending;
    assign port.recovCount = s.recovCount;
    assign port.occurred = s.occurred;
    assign port.latchedPulse = s.latchedPulse;

endmodule : event_supervisor

/* File: hw/event_recovery_limit_latch.sv */
// Recovery supervision of eight drive events with AHB-Lite registers.
// Assumes event pins and the tool-connected pin are asynchronous.
//
// How it works
// - Each event occurrence triggers its configured action.
// - Count recovery after clear exceeds window plus time.
// - Latch event when recovery count reaches maximum.
// - Latched event disables bridge until explicit reset.
// - Counters clear only while configuration tool connected.
// - Maximum settings are unsigned 16-bit read/write.
// - Index 765 holds user-disable maximum.
// - Indices 766, 767 hold travel limit maxima.
// - Indices 768, 769 hold current-limiting maxima.
// - Indices 770, 771 hold saturation, under-voltage maxima.
// - Index 764 holds log-missed maximum, same scheme.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module event_recovery_limit_latch
    import erl_pkg::*;
#(
    parameter logic [15:0] MAX_RECOV_INIT = MAX_RECOV_RESET
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] eventIn,
    input wire logic cfgToolConnected,
    output logic bridgeEnable,
    output logic [7:0] eventAction,
    output logic [7:0] latchedEvents,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    top_state_t s;
    top_state_t next_s;
    logic [7:0] latchedVec;
    logic [7:0] pendingVec;
    logic [7:0] occurredVec;
    logic [7:0] latchedPulseVec;
    logic [7:0][15:0] countVec;
    logic [16:0] clearTime;
    logic accept;
    logic [15:0] irqClr;
    logic [2:0] wIdx;

    // Cleared time that must be exceeded before a recovery counts
    assign clearTime = {1'b0, s.timeoutWin} + {1'b0, s.recovTime};

    // ------------------------------------------------------------
    // Per-event supervisors
    // ------------------------------------------------------------
    for (genvar i = 0; i < EVENT_COUNT; i++) begin : gen_event
        event_sup_if link ();

        // Drive the supervisor from synchronised levels and settings
        assign link.eventLevel = s.sync2[i];
        assign link.maxRecov = s.maxRecov[i];
        assign link.clearTime = clearTime;
        assign link.latchReset = s.latchReset[i];
        assign link.countClear = s.countClear[i];
        assign latchedVec[i] = link.latched;
        assign pendingVec[i] = link.pending;
        assign occurredVec[i] = link.occurred;
        assign latchedPulseVec[i] = link.latchedPulse;
        assign countVec[i] = link.recovCount;

        event_supervisor u_sup (
            .clock(clock),
            .sys_rst(sys_rst),
            .port(link.sup)
        );
    end

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    function automatic logic [31:0] readWord(input logic [11:0] a);
        logic [31:0] w;
        logic [2:0] idx;
        w = 32'h00000000;
        idx = 3'h0;
        case (a)
            ADDR_CONTROL: begin
                w = {31'h00000000, s.bridgeReq};
            end
            ADDR_ACTION: begin
                w = {24'h000000, s.action};
            end
            ADDR_TIMEOUT_WIN: begin
                w = {16'h0000, s.timeoutWin};
            end
            ADDR_RECOV_TIME: begin
                w = {16'h0000, s.recovTime};
            end
            ADDR_EVENT_STATE: begin
                w = {15'h0000, s.sync2[8], pendingVec, latchedVec};
            end
            ADDR_IRQ_STATUS: begin
                w = {16'h0000, s.irqStatus};
            end
            ADDR_IRQ_ENABLE: begin
                w = {16'h0000, s.irqEnable};
            end
            default: begin
                if (a >= ADDR_MAX_FIRST && a <= ADDR_MAX_LAST && a[1:0] == 2'h0) begin
                    idx = 3'((a - ADDR_MAX_FIRST) >> 2);
                    w = {16'h0000, s.maxRecov[idx]};
                end else if (a >= ADDR_COUNT_FIRST && a <= ADDR_COUNT_LAST
                             && a[1:0] == 2'h0) begin
                    idx = 3'((a - ADDR_COUNT_FIRST) >> 2);
                    w = {16'h0000, countVec[idx]};
                end
            end
        endcase
        return w;
    endfunction : readWord

    // ------------------------------------------------------------
    // Next state of the block
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        accept = hsel & htrans[1] & hready;
        irqClr = 16'h0000;
        wIdx = 3'h0;

        // Two-flop synchronisers for the pins
        next_s.sync1 = {cfgToolConnected, eventIn};
        next_s.sync2 = s.sync1;

        // One-cycle strobes toward the supervisors
        next_s.latchReset = 8'h00;
        next_s.countClear = 8'h00;

        // Write data phase
        if (s.wrPending) begin
            case (s.wrAddr)
                ADDR_CONTROL: begin
                    next_s.bridgeReq = hwdata[0];
                end
                ADDR_ACTION: begin
                    next_s.action = hwdata[7:0];
                end
                ADDR_TIMEOUT_WIN: begin
                    next_s.timeoutWin = hwdata[15:0];
                end
                ADDR_RECOV_TIME: begin
                    next_s.recovTime = hwdata[15:0];
                end
                ADDR_LATCH_RESET: begin
                    next_s.latchReset = hwdata[7:0];
                end
                ADDR_COUNT_CLEAR: begin
                    next_s.countClear = hwdata[7:0] & {8{s.sync2[8]}};
                end
                ADDR_IRQ_CLEAR: begin
                    irqClr = hwdata[15:0];
                end
                ADDR_IRQ_ENABLE: begin
                    next_s.irqEnable = hwdata[15:0];
                end
                default: begin
                    // Settings
                    if (s.wrAddr >= ADDR_MAX_FIRST && s.wrAddr <= ADDR_MAX_LAST
                        && s.wrAddr[1:0] == 2'h0) begin
                        wIdx = 3'((s.wrAddr - ADDR_MAX_FIRST) >> 2);
                        next_s.maxRecov[wIdx] = hwdata[15:0];
                    end
                end
            endcase
        end

        // Sticky interrupt status, a new event wins over the clear
        next_s.irqStatus = (s.irqStatus & ~irqClr) | {latchedPulseVec, occurredVec};
        next_s.irq = |(next_s.irqStatus & s.irqEnable);

        // Address phase capture
        next_s.wrPending = accept & hwrite & (hsize == HSIZE_WORD);
        next_s.wrAddr = haddr[11:0];
        if (s.rdLate) begin
            next_s.rdLate = 1'b0;
            next_s.hreadyout = 1'b1;
            next_s.hrdata = readWord(s.rdAddr);
        end else if (accept && !hwrite) begin
            if (s.wrPending) begin
                // Let the pending write land before reading
                next_s.rdLate = 1'b1;
                next_s.hreadyout = 1'b0;
                next_s.rdAddr = haddr[11:0];
            end else begin
                next_s.hrdata = readWord(haddr[11:0]);
            end
        end

        // Event actions and bridge gating
        next_s.eventAction = s.sync2[7:0] & s.action;
        next_s.latchedEvents = latchedVec;
        next_s.bridgeEnable = s.bridgeReq & ~(|latchedVec)
                              & ~(|(pendingVec & s.action));
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.hreadyout <= 1'b1;
            s.maxRecov <= {EVENT_COUNT{MAX_RECOV_INIT}};
            s.action <= ACTION_RESET;
            s.timeoutWin <= TIMEOUT_WIN_RESET;
            s.recovTime <= RECOV_TIME_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign bridgeEnable = s.bridgeEnable;
    assign eventAction = s.eventAction;
    assign latchedEvents = s.latchedEvents;
    assign irq = s.irq;

endmodule : event_recovery_limit_latch

/* File: testbench/erl_monitor.sv */
// Bus and event timing checks for the event recovery supervisor.
// Assumes binding to the top block; sees only its ports.
`timescale 1ns/1ps
module erl_monitor(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] eventIn,
    input wire logic bridgeEnable,
    input wire logic [7:0] eventAction,
    input wire logic [7:0] latchedEvents
);
    // ----------------------------------------
    // Helper ages
    // ----------------------------------------
    logic [3:0] wrAge;
    logic [3:0] rdAge;
    wire logic taken = hsel & htrans[1] & hready;

    // Cycles since the last accepted write and read
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wrAge <= 4'hf;
            rdAge <= 4'hf;
        end else begin
            wrAge <= (taken & hwrite) ? 4'h0 : ((wrAge == 4'hf) ? wrAge : wrAge + 4'h1);
            rdAge <= (taken & ~hwrite) ? 4'h0 : ((rdAge == 4'hf) ? rdAge : rdAge + 4'h1);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence quietIn;
        (eventIn == 8'h00) [*4];
    endsequence
    sequence actionSeen;
        eventAction != 8'h00;
    endsequence

    // Assertions
    bus_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
    wait_short_a: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
    rdata_hold_a: assert property (!$stable(hrdata) |-> rdAge <= 4'h2)
        else $error("hrdata changed without read");
    action_quiet_a: assert property (quietIn |-> eventAction == 8'h00)
        else $error("action without event");
    bridge_action_a: assert property (actionSeen |=> !bridgeEnable)
        else $error("bridge on during event");
    bridge_latch_a: assert property (latchedEvents != 8'h00 |-> !bridgeEnable)
        else $error("bridge on while latched");
    latch_cleared_a: assert property (
        (latchedEvents & ~$past(latchedEvents) & $past(eventIn, 5)) == 8'h00)
        else $error("latched while event present");
    latch_release_a: assert property (
        (~latchedEvents & $past(latchedEvents)) != 8'h00 |-> wrAge <= 4'h6)
        else $error("latch released without write");
endmodule : erl_monitor

bind event_recovery_limit_latch erl_monitor mon (.clock(clock), .sys_rst(sys_rst),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .eventIn(eventIn),
    .bridgeEnable(bridgeEnable), .eventAction(eventAction), .latchedEvents(latchedEvents));

/* File: testbench/ahb_host.sv */
// Host model: AHB-Lite master and configuration tool link.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module ahb_host(
    input wire logic clock,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic cfgToolConnected
);
    // Idle bus and tool absent at start
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cfgToolConnected = 1'b0;
    end

    // One single transfer; entered just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        input logic [2:0] sz, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sz;
        hwdata <= ~hwdata; // Not valid yet
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~hwdata;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
endmodule : ahb_host

/* File: testbench/test_event_recovery_limit_latch.sv */
// Self-checking bench of the event recovery supervisor.
// Assumes the host model drives the bus and the tool link.
`timescale 1ns/1ps
module test_event_recovery_limit_latch import erl_pkg::*;;
    // ----------------------------------------
    // Signals and helpers
    // ----------------------------------------
    logic clock, sys_rst, hsel, hwrite, hreadyout, hresp, cfgToolConnected, bridgeEnable, irq;
    logic [31:0] haddr, hwdata, hrdata, rng, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] eventIn, eventAction, latchedEvents, m;
    logic [11:0] idx [8];
    logic [15:0] vals [8];
    int err_total, n_tests, lim, nK;

    event_recovery_limit_latch DUT (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .eventIn(eventIn), .cfgToolConnected(cfgToolConnected), .bridgeEnable(bridgeEnable),
        .eventAction(eventAction), .latchedEvents(latchedEvents), .irq(irq));
    ahb_host host (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .cfgToolConnected(cfgToolConnected));

    // 40 MHz clock
    always #12.5 clock = ~clock;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Latched mask after k recoveries against setting l
    function automatic logic [7:0] expLatch(input int k, input int l, input logic [7:0] b);
        return (k >= l) ? b : 8'h00;
    endfunction : expLatch

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] r;
        host.xfer(1'b1, a, v, HSIZE_WORD, r);
    endtask : wr
    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0, HSIZE_WORD, r);
        check(what, r, exp);
    endtask : rdChk
    // Event high for a random span, checked while still high
    task automatic pulse(input logic [7:0] b);
        rng = xs(rng);
        eventIn <= b;
        repeat (5 + rng[2:0]) @(posedge clock);
        check("action", 32'(eventAction), 32'(b));
        check("bridge event", 32'(bridgeEnable), 32'h0);
        eventIn <= 8'h00;
    endtask : pulse
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        eventIn = 8'h00;
        rng = 32'h9611;
        idx = '{IDX_MAX_LOG_MISSED, IDX_MAX_USER_DISABLE, IDX_MAX_POS_LIMIT, IDX_MAX_NEG_LIMIT,
            IDX_MAX_CURRENT_LIMIT, IDX_MAX_CONT_CURRENT_LIMIT, IDX_MAX_LOOP_SATURATED,
            IDX_MAX_USER_UNDERVOLT};
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        check("bridge reset", 32'(bridgeEnable), 32'h0);
        // Settings: reset value, full range, distinct per index
        for (int i = 0; i < EVENT_COUNT; i++) begin
            rdChk("max reset", 12'(idx[i] * 4), 32'(MAX_RECOV_RESET));
            rng = xs(rng);
            d = (i == 7) ? 32'hffffffff : rng;
            vals[i] = d[15:0];
            wr(12'(idx[i] * 4), d);
        end
        host.xfer(1'b1, 12'(idx[0] * 4), ~d, 3'h1, d);
        for (int i = 0; i < EVENT_COUNT; i++) begin
            rdChk("max rw", 12'(idx[i] * 4), {16'h0, vals[i]});
            wr(12'(idx[i] * 4), 32'(i % 3));
        end
        rdChk("unmapped", 12'h100, 32'h0);
        wr(ADDR_TIMEOUT_WIN, 32'h3);
        wr(ADDR_RECOV_TIME, 32'h2);
        wr(ADDR_IRQ_ENABLE, 32'hffff);
        wr(ADDR_CONTROL, 32'h1);
        // Each event: recover until latched, clear counter, release
        for (int i = 0; i < EVENT_COUNT; i++) begin
            m = 8'h01 << i;
            lim = i % 3;
            nK = (lim == 0) ? 1 : lim;
            repeat (4) @(posedge clock);
            check("bridge on", 32'(bridgeEnable), 32'h1);
            pulse(m);
            repeat (3) @(posedge clock);
            for (int k = 1; k <= nK; k++) begin
                pulse(m);
                repeat (20) @(posedge clock);
                rdChk("count", ADDR_COUNT_FIRST + 12'(4 * i), 32'(k));
                check("latch", 32'(latchedEvents), 32'(expLatch(k, lim, m)));
            end
            check("bridge latched", 32'(bridgeEnable), 32'h0);
            check("irq on", 32'(irq), 32'h1);
            rdChk("irq status", ADDR_IRQ_STATUS, 32'({m, m}));
            wr(ADDR_IRQ_ENABLE, 32'h0);
            repeat (3) @(posedge clock);
            check("irq masked", 32'(irq), 32'h0);
            wr(ADDR_IRQ_CLEAR, 32'hffff);
            wr(ADDR_IRQ_ENABLE, 32'hffff);
            repeat (3) @(posedge clock);
            check("irq cleared", 32'(irq), 32'h0);
            wr(ADDR_COUNT_CLEAR, 32'(m));
            // Clear strobe reaches the counter one cycle after the write lands
            @(posedge clock);
            rdChk("count kept", ADDR_COUNT_FIRST + 12'(4 * i), 32'(nK));
            host.cfgToolConnected <= 1'b1;
            repeat (4) @(posedge clock);
            rdChk("state tool", ADDR_EVENT_STATE, 32'h00010000 | 32'(m));
            wr(ADDR_COUNT_CLEAR, 32'(m));
            @(posedge clock);
            rdChk("count cleared", ADDR_COUNT_FIRST + 12'(4 * i), 32'h0);
            host.cfgToolConnected <= 1'b0;
            wr(ADDR_LATCH_RESET, 32'(m));
            repeat (4) @(posedge clock);
            check("unlatched", 32'(latchedEvents), 32'h0);
        end
        // Action mask: event 0 without its action keeps the bridge on
        rdChk("action reset", ADDR_ACTION, 32'(ACTION_RESET));
        wr(ADDR_ACTION, 32'hfe);
        eventIn <= 8'h01;
        repeat (6) @(posedge clock);
        check("action masked", 32'(eventAction), 32'h0);
        check("bridge unmasked", 32'(bridgeEnable), 32'h1);
        rdChk("state pending", ADDR_EVENT_STATE, 32'h00000100);
        eventIn <= 8'h00;
        end_sim();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        end_sim();
    end
endmodule : test_event_recovery_limit_latch
